//--- src/cmpc_regs.svh
`ifndef CMPC_REGS_SVH
`define CMPC_REGS_SVH

// register indices (not byte offsets; each register is one aligned word at byte offset 4*index)
`define CMPC_IDX_CONTROL 3'h0
`define CMPC_IDX_INSEL 3'h2
`define CMPC_IDX_INTEN 3'h6
`define CMPC_IDX_STATUS 3'h7

// comparator_control fields
`define CMPC_CTL_ENABLE 0
`define CMPC_CTL_HYS_LO 1
`define CMPC_CTL_EDGE_LO 4
`define CMPC_CTL_PAD 6
`define CMPC_CTL_RUNSLEEP 7
`define CMPC_CTL_MASK 8'hf7

// input_select fields
`define CMPC_SEL_MINUS_LO 0
`define CMPC_SEL_PLUS 3
`define CMPC_SEL_INVERT 7
`define CMPC_SEL_MASK 8'h8b

// interrupt_enable and status fields
`define CMPC_IRQ_BIT 0
`define CMPC_STATE_BIT 4

`define CMPC_RESET_VALUE 8'h00
`define CMPC_SYNC_STAGES 3

`endif

//--- src/cmpc_pkg.sv
`default_nettype none
package cmpc_pkg;

    typedef enum logic [1:0] {
        CMPC_EDGE_ANY = 2'b00,
        CMPC_EDGE_RSVD = 2'b01,
        CMPC_EDGE_FALL = 2'b10,
        CMPC_EDGE_RISE = 2'b11
    } cmpc_edge_e;

    typedef enum logic [1:0] {
        CMPC_HYS_OFF = 2'b00,
        CMPC_HYS_10MV = 2'b01,
        CMPC_HYS_25MV = 2'b10,
        CMPC_HYS_50MV = 2'b11
    } cmpc_hys_e;

    typedef enum logic [1:0] {
        CMPC_MINUS_PIN0 = 2'b00,
        CMPC_MINUS_RSVD1 = 2'b01,
        CMPC_MINUS_VREF = 2'b10,
        CMPC_MINUS_RSVD3 = 2'b11
    } cmpc_minus_e;

    typedef enum logic [1:0] {
        CMPC_BUS_IDLE = 2'b00,
        CMPC_BUS_DONE = 2'b01
    } cmpc_bus_e;

endpackage : cmpc_pkg

`default_nettype wire

//--- src/cmpc_sync.sv
`timescale 1ns/1ps
`default_nettype none

module cmpc_sync #(
    parameter int STAGES = 3
) (
    // clock and reset
    input wire logic sys_clk,
    input wire logic rst_b,
    input wire logic clkRun,
    // level
    input wire logic asyncIn,
    output logic syncOut
);

    logic [STAGES-1:0] chain;

    // only the last stage is read; earlier stages feed the next stage only
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            chain <= '0;
        end else if (clkRun) begin
            chain <= {chain[STAGES-2:0], asyncIn};
        end
    end

    assign syncOut = chain[STAGES-1];

endmodule : cmpc_sync

`default_nettype wire

//--- src/cmpc_edge.sv
`timescale 1ns/1ps
`default_nettype none

module cmpc_edge (
    // clock and reset
    input wire logic sys_clk,
    input wire logic rst_b,
    input wire logic clkRun,
    // level in and mode
    input wire logic level,
    input wire cmpc_pkg::cmpc_edge_e mode,
    output logic hit
);
    import cmpc_pkg::*;

    logic prevLevel;
    logic rise;
    logic fall;

    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            prevLevel <= 1'b0;
        end else if (clkRun) begin
            prevLevel <= level;
        end
    end

    assign rise = level & ~prevLevel;
    assign fall = ~level & prevLevel;

    always_comb begin
        case (mode)
            CMPC_EDGE_ANY: hit = clkRun & (rise | fall);
            CMPC_EDGE_FALL: hit = clkRun & fall;
            CMPC_EDGE_RISE: hit = clkRun & rise;
            default: hit = 1'b0;
        endcase
    end

endmodule : cmpc_edge

`default_nettype wire

//--- src/comparator_control_regs.sv
// Functional notes
// RULE1: keep-running-asleep bit 7 keeps comparator alive in standby; flags frozen without clock.
// RULE2: pad-drive bit 6 puts comparator output on the output pin.
// RULE3: edge field 5:4 picks both, falling or rising edges; 1 reserved.
// RULE4: hysteresis field 2:1 selects off, 10, 25 or 50 mV.
// RULE5: control bit 0 switches comparator on; all control fields reset to zero.
// RULE6: invert bit 7 of input select flips output for every consumer.
// RULE7: plus select bit 3 value 0 routes plus pin zero; 1 reserved.
// RULE8: minus select 0 routes minus pin zero, 2 internal reference; others reserved.
// RULE9: interrupt enable bit 0 at offset 0x06 unmasks comparator interrupt.
// RULE10: status bit 4 shows synchronised output, three cycles behind.
// RULE11: status bit 0 is the interrupt flag, cleared by writing one.
// RULE12: flag sets whenever output toggles as the edge field selects.
// RULE13: interrupt request high while enable and flag both set.
// RULE14: output is one when plus exceeds minus; offered as asynchronous event.
// RULE15: edge detection compares synchronised, inverted output with previous cycle.
//
// Local design decision: the Avalon-MM slave port.
`include "cmpc_regs.svh"
`timescale 1ns/1ps
`default_nettype none

module comparator_control_regs #(
    parameter int SYNC_STAGES = `CMPC_SYNC_STAGES
) (
    // clock and reset
    input wire logic sys_clk,
    input wire logic rst_b,
    // avalon-mm slave
    input wire logic [4:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    output logic avs_response_err,
    // power management
    input wire logic standbySleep,
    // analog core
    input wire logic rawCompare,
    output logic coreEnable,
    output cmpc_pkg::cmpc_hys_e hysteresisLevel,
    output logic plusInputSelect,
    output cmpc_pkg::cmpc_minus_e minusInputSelect,
    // event and pad
    output logic compareEvent,
    output logic padOut,
    output logic padOutEn,
    // interrupt
    output logic irq
);
    import cmpc_pkg::*;

    logic [7:0] comparatorControl;
    logic [7:0] inputSelect;
    logic [7:0] interruptEnable;
    logic compareIrqBit;
    logic compareState;
    logic edgeHit;
    logic clkRun;
    logic coreRunning;
    logic seenOut;
    logic busAccess;
    logic accDone;
    logic wrStrobe;
    logic [2:0] regIdx;
    logic mapped;
    cmpc_bus_e busState;

    function automatic logic isMapped(input logic [2:0] idx);
        isMapped = (idx == `CMPC_IDX_CONTROL) || (idx == `CMPC_IDX_INSEL) ||
                   (idx == `CMPC_IDX_INTEN) || (idx == `CMPC_IDX_STATUS);
    endfunction : isMapped

    // word-aligned byte addresses: index sits in address bits 4:2
    assign regIdx = avs_address[4:2];
    assign mapped = isMapped(regIdx);

    // registered clock stops in standby; comparator may keep running there
    assign clkRun = ~standbySleep; // [RULE1]
    assign coreRunning = comparatorControl[`CMPC_CTL_ENABLE] &
                         (~standbySleep | comparatorControl[`CMPC_CTL_RUNSLEEP]); // [RULE1] [RULE5]
    assign coreEnable = coreRunning;
    assign hysteresisLevel = cmpc_hys_e'(comparatorControl[`CMPC_CTL_HYS_LO +: 2]); // [RULE4]
    assign plusInputSelect = inputSelect[`CMPC_SEL_PLUS]; // [RULE7]
    assign minusInputSelect = cmpc_minus_e'(inputSelect[`CMPC_SEL_MINUS_LO +: 2]); // [RULE8]

    // inversion applies ahead of every consumer, also the asynchronous event path
    assign seenOut = coreRunning & (rawCompare ^ inputSelect[`CMPC_SEL_INVERT]); // [RULE6] [RULE14]
    assign compareEvent = seenOut; // [RULE14]
    // pad path is combinational so it still updates while the clock is stopped
    assign padOut = seenOut;
    assign padOutEn = comparatorControl[`CMPC_CTL_PAD] & coreRunning; // [RULE2]

    cmpc_sync #(
        .STAGES(SYNC_STAGES)
    ) uSync (
        .sys_clk(sys_clk),
        .rst_b(rst_b),
        .clkRun(clkRun),
        .asyncIn(seenOut),
        .syncOut(compareState) // [RULE10]
    );

    cmpc_edge uEdge (
        .sys_clk(sys_clk),
        .rst_b(rst_b),
        .clkRun(clkRun),
        .level(compareState), // [RULE15]
        .mode(cmpc_edge_e'(comparatorControl[`CMPC_CTL_EDGE_LO +: 2])), // [RULE3]
        .hit(edgeHit)
    );

    // bus: one wait cycle, then the answer with waitrequest low
    assign busAccess = avs_read | avs_write;
    assign accDone = (busState == CMPC_BUS_DONE);
    assign avs_waitrequest = ~(busAccess & accDone);
    assign wrStrobe = avs_write & accDone & avs_byteenable[0];

    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            busState <= CMPC_BUS_IDLE;
        end else begin
            case (busState)
                CMPC_BUS_IDLE: busState <= busAccess ? CMPC_BUS_DONE : CMPC_BUS_IDLE;
                CMPC_BUS_DONE: busState <= CMPC_BUS_IDLE;
                default: busState <= CMPC_BUS_IDLE;
            endcase
        end
    end

    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            comparatorControl <= `CMPC_RESET_VALUE; // [RULE5]
        end else if (wrStrobe && regIdx == `CMPC_IDX_CONTROL) begin
            comparatorControl <= avs_writedata[7:0] & `CMPC_CTL_MASK;
        end
    end

    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            inputSelect <= `CMPC_RESET_VALUE;
        end else if (wrStrobe && regIdx == `CMPC_IDX_INSEL) begin
            inputSelect <= avs_writedata[7:0] & `CMPC_SEL_MASK;
        end
    end

    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            interruptEnable <= `CMPC_RESET_VALUE;
        end else if (wrStrobe && regIdx == `CMPC_IDX_INTEN) begin
            interruptEnable <= {7'h00, avs_writedata[`CMPC_IRQ_BIT]}; // [RULE9]
        end
    end

    // a new edge in the clearing cycle wins over the clear
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            compareIrqBit <= 1'b0;
        end else if (edgeHit) begin
            compareIrqBit <= 1'b1; // [RULE12]
        end else if (wrStrobe && regIdx == `CMPC_IDX_STATUS && avs_writedata[`CMPC_IRQ_BIT]) begin
            compareIrqBit <= 1'b0; // [RULE11]
        end
    end

    assign irq = interruptEnable[`CMPC_IRQ_BIT] & compareIrqBit; // [RULE13]

    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            avs_readdata <= 32'h0000_0000;
            avs_response_err <= 1'b0;
        end else if (avs_read && busState == CMPC_BUS_IDLE) begin
            avs_response_err <= ~mapped;
            case (regIdx)
                `CMPC_IDX_CONTROL: avs_readdata <= {24'h00_0000, comparatorControl};
                `CMPC_IDX_INSEL: avs_readdata <= {24'h00_0000, inputSelect};
                `CMPC_IDX_INTEN: avs_readdata <= {24'h00_0000, interruptEnable};
                `CMPC_IDX_STATUS: avs_readdata <= {27'h000_0000, compareState, 3'h0, compareIrqBit}; // [RULE10]
                default: avs_readdata <= 32'h0000_0000;
            endcase
        end else if (avs_write && busState == CMPC_BUS_IDLE) begin
            avs_response_err <= ~mapped;
        end
    end

endmodule : comparator_control_regs

`default_nettype wire

//--- tb/cmpc_core_model.sv
`timescale 1ns/1ps
`default_nettype none

module cmpc_core_model (
    // analog levels in millivolts
    input wire logic [11:0] plusMv,
    input wire logic [11:0] minusMv,
    input wire logic [11:0] refMv,
    // controls from the block
    input wire logic coreEnable,
    input wire cmpc_pkg::cmpc_minus_e minusInputSelect,
    output logic rawCompare
);
    import cmpc_pkg::*;
    // only plus pin zero exists, so the plus select is not looked at
    assign rawCompare = coreEnable &&
        (plusMv > ((minusInputSelect == CMPC_MINUS_VREF) ? refMv : minusMv));
endmodule : cmpc_core_model

`default_nettype wire

//--- tb/comparator_control_regs_chk.sv
`timescale 1ns/1ps
`default_nettype none

module comparator_control_regs_chk (
    // clock and reset
    input wire logic sys_clk,
    input wire logic rst_b,
    // bus
    input wire logic [4:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_readdata,
    input wire logic avs_waitrequest,
    input wire logic avs_response_err,
    // core, pad and interrupt
    input wire logic standbySleep,
    input wire logic coreEnable,
    input wire logic compareEvent,
    input wire logic padOut,
    input wire logic padOutEn,
    input wire logic irq
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_b);
    logic req;
    logic mapped;
    assign req = avs_read || avs_write;
    assign mapped = avs_address[4:2] inside {3'h0, 3'h2, 3'h6, 3'h7};
    a_wait_one: assert property (req && avs_waitrequest |=> !avs_waitrequest)
        else $error("bus answer late");
    a_wait_idle: assert property (!req |-> avs_waitrequest)
        else $error("answer without request");
    a_err_map: assert property (req && !avs_waitrequest |-> avs_response_err == !mapped)
        else $error("error response wrong");
    a_rdata_high: assert property (!avs_waitrequest |-> avs_readdata[31:8] == 24'h0)
        else $error("upper read data not zero");
    a_pad_gate: assert property (padOutEn |-> coreEnable && padOut == compareEvent)
        else $error("pad output wrong");
    a_event_off: assert property (!coreEnable |-> !compareEvent)
        else $error("event while core off");
    a_irq_hold: assert property (irq && !avs_write |=> irq)
        else $error("irq dropped without write");
    a_irq_frozen: assert property (standbySleep && !avs_write |=> $stable(irq))
        else $error("irq moved in standby");
    a_core_gate: assert property ($fell(coreEnable) && !$past(avs_write) |-> standbySleep)
        else $error("core dropped without cause");
endmodule : comparator_control_regs_chk

bind comparator_control_regs comparator_control_regs_chk i_chk (.sys_clk(sys_clk), .rst_b(rst_b),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .avs_response_err(avs_response_err), .standbySleep(standbySleep),
    .coreEnable(coreEnable), .compareEvent(compareEvent), .padOut(padOut), .padOutEn(padOutEn), .irq(irq));

`default_nettype wire

//--- tb/tb_comparator_control_regs.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin checked++; if ((g) !== (e)) begin failures++; $display("MISMATCH %s exp %h got %h", nm, e, g); end end

module tb_comparator_control_regs;
    import cmpc_pkg::*;
    logic sys_clk = 1'b0;
    logic rst_b = 1'b0;
    logic [4:0] avs_address = 5'h0;
    logic avs_read = 1'b0;
    logic avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h0;
    logic [31:0] avs_readdata;
    logic avs_waitrequest;
    logic avs_response_err;
    logic standbySleep = 1'b0;
    logic rawCompare;
    logic coreEnable;
    cmpc_hys_e hysteresisLevel;
    logic plusInputSelect;
    cmpc_minus_e minusInputSelect;
    logic compareEvent;
    logic padOut;
    logic padOutEn;
    logic irq;
    logic [11:0] plusMv = 12'h0;
    logic [7:0] rd;
    logic err;
    int failures = 0;
    int checked = 0;
    always #2.5 sys_clk = !sys_clk;
    comparator_control_regs i_dut (.sys_clk(sys_clk), .rst_b(rst_b), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(4'h1),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .avs_response_err(avs_response_err),
        .standbySleep(standbySleep), .rawCompare(rawCompare), .coreEnable(coreEnable),
        .hysteresisLevel(hysteresisLevel), .plusInputSelect(plusInputSelect), .minusInputSelect(minusInputSelect),
        .compareEvent(compareEvent), .padOut(padOut), .padOutEn(padOutEn), .irq(irq));
    cmpc_core_model i_core (.plusMv(plusMv), .minusMv(12'h100), .refMv(12'h300), .coreEnable(coreEnable),
        .minusInputSelect(minusInputSelect), .rawCompare(rawCompare));
    task automatic give_verdict();
        $display("checked %0d failures %0d", checked, failures);
        if (failures == 0 && checked > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask : give_verdict
    // waitrequest is read right after the edge, before any update, so it is its sampled value
    task automatic xfer(input logic wr, input logic [2:0] idx, input logic [7:0] d);
        int n;
        n = 0;
        @(posedge sys_clk);
        avs_address <= {idx, 2'b00};
        avs_writedata <= {24'h0, d};
        avs_write <= wr;
        avs_read <= !wr;
        do begin
            @(posedge sys_clk);
            n++;
        end while (avs_waitrequest !== 1'b0 && n < 20);
        rd = avs_readdata[7:0];
        err = avs_response_err;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
        if (n >= 20) failures++;
    endtask : xfer
    initial begin
        #100000;
        failures++;
        give_verdict();
    end
    initial begin
        repeat (4) @(posedge sys_clk);
        rst_b <= 1'b1;
        for (int i = 0; i < 8; i++) begin
            xfer(1'b0, i[2:0], 8'h0);
            `CHK("reset", 8'h0, rd)
            `CHK("err", !(i inside {0, 2, 6, 7}), err)
        end
        xfer(1'b1, 3'h0, 8'hff);
        xfer(1'b0, 3'h0, 8'h0);
        `CHK("ctrl", 8'hf7, rd)
        `CHK("hys", CMPC_HYS_50MV, hysteresisLevel)
        `CHK("paden", 1'b1, padOutEn)
        xfer(1'b1, 3'h2, 8'hff);
        xfer(1'b0, 3'h2, 8'h0);
        `CHK("sel", 8'h8b, rd)
        `CHK("minus", CMPC_MINUS_RSVD3, minusInputSelect)
        `CHK("plus", 1'b1, plusInputSelect)
        xfer(1'b1, 3'h2, 8'h80);
        @(negedge sys_clk);
        `CHK("inv", 1'b1, compareEvent)
        xfer(1'b1, 3'h2, 8'h00);
        xfer(1'b1, 3'h6, 8'h01);
        for (int m = 0; m < 4; m++) begin
            xfer(1'b1, 3'h0, {2'b00, m[1:0], 4'h1});
            xfer(1'b1, 3'h7, 8'h01);
            plusMv <= 12'h200;
            repeat (8) @(posedge sys_clk);
            xfer(1'b1, 3'h7, 8'h00);
            xfer(1'b0, 3'h7, 8'h0);
            `CHK("rise", 8'h10 | (m == 0 || m == 3), rd)
            `CHK("irq", (m == 0 || m == 3), irq)
            xfer(1'b1, 3'h7, 8'h01);
            plusMv <= 12'h0;
            repeat (8) @(posedge sys_clk);
            xfer(1'b0, 3'h7, 8'h0);
            `CHK("fall", 8'h00 | (m == 0 || m == 2), rd)
        end
        plusMv <= 12'h200;
        repeat (8) @(posedge sys_clk);
        `CHK("irqset", 1'b1, irq)
        xfer(1'b1, 3'h6, 8'h00);
        @(negedge sys_clk);
        `CHK("mask", 1'b0, irq)
        xfer(1'b0, 3'h7, 8'h0);
        `CHK("flagkept", 8'h11, rd)
        xfer(1'b1, 3'h2, 8'h02);
        @(negedge sys_clk);
        `CHK("vref", 1'b0, rawCompare)
        repeat (8) @(posedge sys_clk);
        standbySleep <= 1'b1;
        xfer(1'b1, 3'h0, 8'h01);
        @(negedge sys_clk);
        `CHK("halt", 1'b0, coreEnable)
        xfer(1'b1, 3'h0, 8'h81);
        @(negedge sys_clk);
        `CHK("keep", 1'b1, coreEnable)
        xfer(1'b1, 3'h7, 8'h01);
        plusMv <= 12'h400;
        repeat (8) @(posedge sys_clk);
        `CHK("evt", 1'b1, compareEvent)
        xfer(1'b0, 3'h7, 8'h0);
        `CHK("frozen", 8'h00, rd)
        standbySleep <= 1'b0;
        repeat (8) @(posedge sys_clk);
        xfer(1'b0, 3'h7, 8'h0);
        `CHK("wake", 8'h11, rd)
        give_verdict();
    end
endmodule : tb_comparator_control_regs

`default_nettype wire
